/* design/xsp_core.v */
// Execute unit for the exclusive-OR instruction forms, with stack pointer.
// Software loads an opcode and operand bytes over APB and starts it.
// Assumes a single 200 MHz clock and an APB master on the same clock.
//
// How it works
// - 01101rrr xors the selected work_reg_n into accum_register, one machine cycle.
// - 0110011i xors RAM at pointer_reg_i (bit 0 picks) into accumulator.
// - 0x65 fetches a direct address and xors that byte into accumulator.
// - 0x64 fetches an immediate byte and xors it into accumulator.
// - 0x62 xors accumulator into the direct byte, writing back in place.
// - 0x63 uses address then constant, xors in place, two machine cycles.
// - No status flag changes; only the destination byte is written.
// - Port operand is read from its output latch, never the pins.
// - Unoccupied special addresses ignore writes and read as zero.
// - Stack pointer increments before each push or call store.
// - Reset loads stack pointer with 07h; first push lands at 08h.
`include "xsp_defines.vh"
module xsp_core (
   input wire i_sys_clk,
   input wire i_rst_n,
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [11:0] i_paddr,
   input wire [31:0] i_pwdata,
   input wire [7:0] i_port_pins,
   output reg [31:0] o_prdata,
   output reg o_pready,
   output reg o_pslverr,
   output reg [7:0] o_port_latch,
   output reg o_busy
);
   localparam ST_IDLE = 2'h0;
   localparam ST_EXEC = 2'h1;
   localparam ST_WAIT = 2'h2;

   reg [7:0] ram_r [0:127];
   reg [7:0] acc_r;
   reg [7:0] opc_r;
   reg [15:0] ops_r;
   reg [1:0] rbank_r;
   reg [6:0] rama_r;
   reg [1:0] state_r;
   reg [3:0] clk_cnt_r;
   reg [1:0] mc_left_r;
   reg [1:0] last_cyc_r;
   reg ill_r;
   reg [7:0] pin_m_r;
   reg [7:0] pin_r;

   wire [7:0] sp_val;
   wire [7:0] sp_next;
   wire apb_acc = i_psel & i_penable & ~o_pready;
   wire apb_wr = apb_acc & i_pwrite;
   wire go = apb_wr && (i_paddr == `XSP_REG_CTRL) && i_pwdata[`XSP_CTRL_GO] && !o_busy;
   wire sp_bus_wr = apb_wr && (i_paddr == `XSP_REG_SP) && !o_busy;

   // Opcode classes
   wire is_reg = (opc_r[7:3] == `XSP_OP_REG_HI);
   wire is_ind = (opc_r[7:1] == `XSP_OP_IND_HI);
   wire is_imm = (opc_r == `XSP_OP_IMM);
   wire is_dsrc = (opc_r == `XSP_OP_DIR_SRC);
   wire is_ddst = (opc_r == `XSP_OP_DIR_DST);
   wire is_dimm = (opc_r == `XSP_OP_DIR_IMM);
   wire is_push = (opc_r == `XSP_OP_PUSH);
   wire is_call = (opc_r == `XSP_OP_CALL);
   wire is_xor_acc = is_reg | is_ind | is_imm | is_dsrc;
   wire known = is_xor_acc | is_ddst | is_dimm | is_push | is_call;

   // Working register and pointer register sit in the selected bank
   wire [6:0] reg_addr = {2'b00, rbank_r, opc_r[2:0]};
   wire [6:0] ptr_addr = {2'b00, rbank_r, 2'b00, opc_r[0]};
   wire [7:0] ptr_val = ram_r[ptr_addr];
   wire [7:0] dir_addr = ops_r[7:0];
   wire [7:0] imm_data = is_dimm ? ops_r[15:8] : ops_r[7:0];

   // Direct read: low half is RAM, upper half holds only a few registers
   reg [7:0] dir_rd;
   reg dir_hit;
   always @* begin
      dir_rd = 8'h00;
      dir_hit = 1'b1;
      if (!dir_addr[7]) begin
         dir_rd = ram_r[dir_addr[6:0]];
      end else begin
         case (dir_addr)
            `XSP_ADDR_PORT: dir_rd = o_port_latch;
            `XSP_ADDR_SP: dir_rd = sp_val;
            `XSP_ADDR_ACC: dir_rd = acc_r;
            default: begin
               dir_rd = 8'h00;
               dir_hit = 1'b0;
            end
         endcase
      end
   end

   // Second operand chosen per form
   reg [7:0] opnd_b;
   always @* begin
      opnd_b = 8'h00;
      if (is_reg) begin
         opnd_b = ram_r[reg_addr];
      end else if (is_ind) begin
         opnd_b = ram_r[ptr_val[6:0]];
      end else if (is_dsrc | is_ddst) begin
         opnd_b = dir_rd;
      end else if (is_imm) begin
         opnd_b = imm_data;
      end
   end

   wire [7:0] opnd_a = is_dimm ? dir_rd : acc_r;
   wire [7:0] opnd_c = is_dimm ? imm_data : opnd_b;
   wire [7:0] xor_res;

   // Eight independent lanes keep bits from mixing
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : lane
         xsp_xor_lane u_lane (
            .i_a(opnd_a[g]),
            .i_b(opnd_c[g]),
            .o_y(xor_res[g])
         );
      end
   endgenerate

   wire exec_done = (state_r == ST_WAIT) && (clk_cnt_r == `XSP_MC_CLKS) && (mc_left_r == 2'h1);
   wire sp_inc = exec_done && (is_push | is_call);
   // Push stores the direct byte, call stores its operand byte
   wire [7:0] push_data = is_push ? dir_rd : ops_r[7:0];
   // Machine cycles the decoded form needs
   wire [1:0] mc_need = is_dimm ? `XSP_MC_LONG : `XSP_MC_SHORT;

   // Destination strobes, all at the end of the last machine cycle
   wire wr_dir = exec_done & (is_ddst | is_dimm);
   wire acc_dir_wr = wr_dir && (dir_addr == `XSP_ADDR_ACC);
   wire port_dir_wr = wr_dir && (dir_addr == `XSP_ADDR_PORT);
   wire sp_dir_wr = wr_dir && (dir_addr == `XSP_ADDR_SP);
   wire ram_dir_wr = wr_dir && !dir_addr[7];

   // Bus writes land only while no instruction runs, so they never race a result
   wire bus_wr_ok = apb_wr && !o_busy;
   wire acc_bus_wr = bus_wr_ok && (i_paddr == `XSP_REG_ACC);
   wire port_bus_wr = bus_wr_ok && (i_paddr == `XSP_REG_PORT);
   wire ramd_bus_wr = bus_wr_ok && (i_paddr == `XSP_REG_RAMD);

   // The stack pointer is a direct-space destination as well
   wire sp_wr = sp_bus_wr | sp_dir_wr;
   wire [7:0] sp_wdata = sp_dir_wr ? xor_res : i_pwdata[7:0];

   xsp_sp_unit u_sp (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_inc(sp_inc),
      .i_wr(sp_wr),
      .i_wdata(sp_wdata),
      .o_sp(sp_val),
      .o_sp_next(sp_next)
   );

   // Pin levels are asynchronous; two stages before anything reads them
   always @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         pin_m_r <= 8'h00;
         pin_r <= 8'h00;
      end else begin
         pin_m_r <= i_port_pins;
         pin_r <= pin_m_r;
      end
   end

   // Sequencer: machine cycle is twelve clocks; the three-byte form spends two
   always @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         state_r <= ST_IDLE;
         clk_cnt_r <= 4'h0;
         mc_left_r <= 2'h0;
         last_cyc_r <= 2'h0;
         ill_r <= 1'b0;
         o_busy <= 1'b0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (go) begin
                  state_r <= ST_EXEC;
                  o_busy <= 1'b1;
               end
            end
            ST_EXEC: begin
               ill_r <= ~known;
               mc_left_r <= mc_need;
               last_cyc_r <= mc_need;
               clk_cnt_r <= 4'h0;
               state_r <= known ? ST_WAIT : ST_IDLE;
               o_busy <= known;
            end
            ST_WAIT: begin
               if (clk_cnt_r == `XSP_MC_CLKS) begin
                  clk_cnt_r <= 4'h0;
                  mc_left_r <= mc_left_r - 2'h1;
                  if (mc_left_r == 2'h1) begin
                     state_r <= ST_IDLE;
                     o_busy <= 1'b0;
                  end
               end else begin
                  clk_cnt_r <= clk_cnt_r + 4'h1;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // Accumulator: result of its own forms, a direct write to its address, or a bus load
   always @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         acc_r <= 8'h00;
      end else if (exec_done && is_xor_acc) begin
         acc_r <= xor_res;
      end else if (acc_dir_wr) begin
         acc_r <= xor_res;
      end else if (acc_bus_wr) begin
         acc_r <= i_pwdata[7:0];
      end
   end

   // Port latch: only written values move it; pin levels never feed back into it
   always @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         o_port_latch <= `XSP_PORT_RESET;
      end else if (port_dir_wr) begin
         o_port_latch <= xor_res;
      end else if (port_bus_wr) begin
         o_port_latch <= i_pwdata[7:0];
      end
   end

   // RAM: result writes, push stores at the incremented pointer, bus writes
   always @(posedge i_sys_clk) begin
      if (ram_dir_wr) begin
         ram_r[dir_addr[6:0]] <= xor_res;
      end else if (sp_inc) begin
         ram_r[sp_next[6:0]] <= push_data;
      end else if (ramd_bus_wr) begin
         ram_r[rama_r] <= i_pwdata[7:0];
      end
   end

   // Status word assembled from named field positions
   reg [31:0] stat_word;
   always @* begin
      stat_word = 32'h00000000;
      stat_word[`XSP_STAT_BUSY] = o_busy;
      stat_word[`XSP_STAT_ILL] = ill_r;
      stat_word[`XSP_STAT_CYC_HI:`XSP_STAT_CYC_LO] = last_cyc_r;
   end

   // APB register writes and single wait-state answer
   always @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         opc_r <= 8'h00;
         ops_r <= 16'h0000;
         rbank_r <= 2'h0;
         rama_r <= 7'h00;
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= 32'h00000000;
      end else begin
         o_pready <= apb_acc;
         o_pslverr <= 1'b0;
         if (apb_wr && !o_busy) begin
            case (i_paddr)
               `XSP_REG_OPC: opc_r <= i_pwdata[7:0];
               `XSP_REG_OPS: ops_r <= i_pwdata[15:0];
               `XSP_REG_RAMA: rama_r <= i_pwdata[6:0];
               `XSP_REG_RBANK: rbank_r <= i_pwdata[1:0];
               default: rama_r <= rama_r;
            endcase
         end
         if (apb_acc) begin
            o_prdata <= 32'h00000000;
            case (i_paddr)
               `XSP_REG_CTRL: o_prdata <= 32'h00000000;
               `XSP_REG_OPC: o_prdata <= {24'h000000, opc_r};
               `XSP_REG_OPS: o_prdata <= {16'h0000, ops_r};
               `XSP_REG_ACC: o_prdata <= {24'h000000, acc_r};
               `XSP_REG_SP: o_prdata <= {24'h000000, sp_val};
               `XSP_REG_PORT: o_prdata <= {16'h0000, pin_r, o_port_latch};
               `XSP_REG_STAT: o_prdata <= stat_word;
               `XSP_REG_RAMA: o_prdata <= {25'h0, rama_r};
               `XSP_REG_RAMD: o_prdata <= {24'h000000, ram_r[rama_r]};
               `XSP_REG_RBANK: o_prdata <= {30'h0, rbank_r};
               default: o_pslverr <= 1'b1;
            endcase
         end
      end
   end
endmodule

/* design/xsp_defines.vh */
// Constants for the exclusive-OR execute block and stack pointer.
// Assumes inclusion by bare name from the design files.
`ifndef XSP_DEFINES_VH
`define XSP_DEFINES_VH
// Opcodes and opcode fields
`define XSP_OP_REG_HI 5'h0d
`define XSP_OP_IND_HI 7'h33
`define XSP_OP_IMM 8'h64
`define XSP_OP_DIR_SRC 8'h65
`define XSP_OP_DIR_DST 8'h62
`define XSP_OP_DIR_IMM 8'h63
`define XSP_OP_PUSH 8'hc0
`define XSP_OP_CALL 8'h12
// Stack pointer reset value
`define XSP_SP_RESET 8'h07
// Direct addresses of the modelled special registers, and the port latch reset value
`define XSP_SFR_BASE 8'h80
`define XSP_ADDR_PORT 8'h90
`define XSP_ADDR_SP 8'h81
`define XSP_ADDR_ACC 8'he0
`define XSP_PORT_RESET 8'hff
// APB byte offsets
`define XSP_REG_CTRL 12'h000
`define XSP_REG_OPC 12'h004
`define XSP_REG_OPS 12'h008
`define XSP_REG_ACC 12'h00c
`define XSP_REG_SP 12'h010
`define XSP_REG_PORT 12'h014
`define XSP_REG_STAT 12'h018
`define XSP_REG_RAMA 12'h01c
`define XSP_REG_RAMD 12'h020
`define XSP_REG_RBANK 12'h024
// Field positions, and the last clock count of a machine cycle
`define XSP_CTRL_GO 0
`define XSP_STAT_BUSY 0
`define XSP_STAT_ILL 1
`define XSP_STAT_CYC_LO 8
`define XSP_STAT_CYC_HI 9
`define XSP_MC_CLKS 4'hb
// Machine cycles per instruction form
`define XSP_MC_SHORT 2'h1
`define XSP_MC_LONG 2'h2
`endif

/* design/xsp_sp_unit.v */
// Stack pointer with reset value and pre-increment on push or call.
// Assumes one clock, synchronous active-low reset.
`include "xsp_defines.vh"
module xsp_sp_unit (
   input wire i_sys_clk,
   input wire i_rst_n,
   input wire i_inc,
   input wire i_wr,
   input wire [7:0] i_wdata,
   output wire [7:0] o_sp,
   output wire [7:0] o_sp_next
);
   reg [7:0] sp_r;
   assign o_sp = sp_r;
   assign o_sp_next = sp_r + 8'h01;
   // Increment wins over a plain write; both in one cycle cannot happen here
   always @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         sp_r <= `XSP_SP_RESET;
      end else if (i_inc) begin
         sp_r <= o_sp_next;
      end else if (i_wr) begin
         sp_r <= i_wdata;
      end
   end
endmodule

/* design/xsp_xor_lane.v */
// One bit lane of the exclusive-OR unit.
// Assumes the instantiating module combines eight lanes.
module xsp_xor_lane (
   input wire i_a,
   input wire i_b,
   output wire o_y
);
   // Each lane sees only its own two bits
   assign o_y = i_a ^ i_b;
endmodule

/* verification/tb_top.sv */
// Self-checking bench for the exclusive-OR execute block over APB.
// Assumes xsp_core on one 200 MHz clock with synchronous active-low reset.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   reg i_sys_clk = 0, i_rst_n = 0, i_psel = 0, i_penable = 0, i_pwrite = 0;
   reg [11:0] i_paddr = 12'h0;
   reg [31:0] i_pwdata = 32'h0, rd, seed = 32'h2b;
   reg [7:0] i_port_pins = 8'h0, acc, sp, prt, op, b1, t, pv;
   reg [7:0] ram [128];
   reg [7:0] atab [4] = '{8'h90, 8'h85, 8'he0, 8'h81};
   reg [7:0] ftab [8] = '{8'h68, 8'h66, 8'h67, 8'h64, 8'h65, 8'h62, 8'h63, 8'h6f};
   reg [1:0] bank;
   reg err;
   int fail_count = 0, total_checks = 0, i;
   wire [31:0] o_prdata;
   wire [7:0] o_port_latch;
   wire o_pready, o_pslverr, o_busy;
   xsp_core DUT (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_psel(i_psel),
      .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
      .i_port_pins(i_port_pins), .o_prdata(o_prdata), .o_pready(o_pready),
      .o_pslverr(o_pslverr), .o_port_latch(o_port_latch), .o_busy(o_busy));
   initial forever #2.5 i_sys_clk = ~i_sys_clk;
   function [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task chk(input [31:0] s, input [31:0] e);
      total_checks++;
      if (s !== e) begin
         fail_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task report_and_stop;
      $display("checks=%0d mismatches=%0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // One APB transfer; holds the request until pready is seen at an edge
   task apb(input w, input [11:0] a, input [31:0] d);
      int n;
      @(posedge i_sys_clk);
      i_psel <= 1; i_penable <= 0; i_pwrite <= w; i_paddr <= a; i_pwdata <= d;
      @(posedge i_sys_clk);
      i_penable <= 1;
      n = 0;
      do begin @(posedge i_sys_clk); n++; end while (o_pready !== 1'b1 && n < 20);
      if (o_pready !== 1'b1) begin fail_count++; report_and_stop; end
      rd = o_prdata; err = o_pslverr; i_psel <= 0; i_penable <= 0;
   endtask
   task mw(input [7:0] a, input [7:0] v);
      apb(1, 12'h01c, {24'h0, a}); apb(1, 12'h020, {24'h0, v});
   endtask
   // Direct space as software sees it: RAM, port latch, accumulator, stack pointer
   function [7:0] dget(input [7:0] a);
      if (!a[7]) return ram[a[6:0]];
      return a == 8'h90 ? prt : a == 8'he0 ? acc : a == 8'h81 ? sp : 8'h00;
   endfunction
   task dset(input [7:0] a, input [7:0] v);
      if (!a[7]) ram[a[6:0]] = v;
      else if (a == 8'h90) prt = v;
      else if (a == 8'he0) acc = v;
      else if (a == 8'h81) sp = v;
   endtask
   // Start one instruction, wait for it, then apply the model and compare
   task run(input [7:0] o, input [7:0] a, input [7:0] c);
      int n;
      pv = ~prt;
      i_port_pins <= pv;
      apb(1, 12'h004, {24'h0, o}); apb(1, 12'h008, {16'h0, c, a}); apb(1, 12'h000, 32'h1);
      n = 0;
      do begin apb(0, 12'h018, 32'h0); n++; end while (rd[0] !== 1'b0 && n < 50);
      if (rd[0] !== 1'b0) begin fail_count++; report_and_stop; end
      if (o[7:4] == 4'h6) chk({30'h0, rd[9:8]}, o == 8'h63 ? 32'h2 : 32'h1);
      if (o[7:3] == 5'h0d) acc = acc ^ ram[{2'h0, bank, o[2:0]}];
      else if (o[7:1] == 7'h33) acc = acc ^ ram[ram[{2'h0, bank, 2'h0, o[0]}][6:0]];
      else case (o)
         8'h64: acc = acc ^ a;
         8'h65: acc = acc ^ dget(a);
         8'h62: dset(a, dget(a) ^ acc);
         8'h63: dset(a, dget(a) ^ c);
         8'hc0: begin t = dget(a); sp++; ram[sp[6:0]] = t; end
         8'h12: begin sp++; ram[sp[6:0]] = a; end
         default: ;
      endcase
      apb(0, 12'h00c, 32'h0); chk({24'h0, rd[7:0]}, {24'h0, acc});
      apb(0, 12'h010, 32'h0); chk({24'h0, rd[7:0]}, {24'h0, sp});
      apb(0, 12'h014, 32'h0); chk({24'h0, rd[7:0]}, {24'h0, prt});
      chk({24'h0, rd[15:8]}, {24'h0, pv});
      chk({24'h0, o_port_latch}, {24'h0, prt});
      t = o[7] || o == 8'h12 ? sp : a;
      // Point the RAM index at the destination, then read it without writing
      if (!t[7]) begin
         apb(1, 12'h01c, {24'h0, t});
         apb(0, 12'h020, 32'h0);
         chk({24'h0, rd[7:0]}, {24'h0, ram[t[6:0]]});
      end
   endtask
   initial begin
      repeat (16) @(posedge i_sys_clk);
      i_rst_n <= 1;
      acc = 8'h0; sp = 8'h07; prt = 8'hff; bank = 2'h0;
      apb(0, 12'h010, 32'h0); chk(rd, 32'h07);
      apb(0, 12'h014, 32'h0); chk({24'h0, rd[7:0]}, 32'hff);
      for (i = 0; i < 128; i++) begin
         ram[i] = i < 32 ? rnd() & 8'h7f : rnd();
         mw(i[7:0], ram[i]);
      end
      run(8'hc0, 8'h30, 8'h0);
      run(8'h12, 8'h5a, 8'h0);
      // An undecoded opcode changes nothing and flags itself in the status word
      run(8'ha5, 8'h30, 8'h0);
      apb(0, 12'h018, 32'h0);
      chk({31'h0, rd[1]}, 32'h1);
      apb(0, 12'h040, 32'h0); chk({31'h0, err}, 32'h1);
      for (i = 0; i < 64; i++) begin
         bank = rnd(); apb(1, 12'h024, {30'h0, bank});
         acc = rnd(); apb(1, 12'h00c, {24'h0, acc});
         if (i % 8 == 3) begin prt = rnd(); apb(1, 12'h014, {24'h0, prt}); end
         op = ftab[i % 8];
         if (op[3]) op[2:0] = rnd();
         if (op[7:1] == 7'h33) begin
            t = rnd() & 8'h7f; ram[{2'h0, bank, 2'h0, op[0]}] = t;
            mw({3'h0, bank, 2'h0, op[0]}, t);
         end
         rd = rnd(); b1 = rd[9] ? {1'b0, rd[6:0]} : atab[rd[11:10]];
         // Results aimed at an unoccupied address carry only zeros
         if (op[7:1] == 7'h31 && b1 == 8'h85) begin
            acc = 8'h0;
            apb(1, 12'h00c, 32'h0);
            rd[23:16] = 8'h0;
         end
         run(op, b1, rd[23:16]);
      end
      // Reset in mid-run restores the stack pointer and port latch
      i_rst_n <= 0;
      repeat (3) @(posedge i_sys_clk);
      i_rst_n <= 1;
      sp = 8'h07; acc = 8'h0; prt = 8'hff; bank = 2'h0;
      run(8'hc0, 8'h90, 8'h0);
      report_and_stop;
   end
endmodule

/* verification/xsp_core_checker.sv */
// Assertions on the APB side and port latch of the exclusive-OR execute block.
// Assumes it is bound to xsp_core and shares its single clock.
module xsp_core_checker (
   input wire i_sys_clk,
   input wire i_rst_n,
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [11:0] i_paddr,
   input wire [31:0] i_pwdata,
   input wire [7:0] i_port_pins,
   input wire [31:0] o_prdata,
   input wire o_pready,
   input wire o_pslverr,
   input wire [7:0] o_port_latch,
   input wire o_busy
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   wire acs = i_psel && i_penable && !o_pready;
   reg [7:0] op_r;
   reg [4:0] cnt_r;
   // Last opcode written, and how many cycles busy has stood
   always @(posedge i_sys_clk) begin
      if (acs && i_pwrite && i_paddr == 12'h004) op_r <= i_pwdata[7:0];
      cnt_r <= o_busy ? cnt_r + 5'h01 : 5'h00;
   end
   property p_ready; acs |=> o_pready; endproperty
   a_ready: assert property (p_ready) else $error("pready late");
   property p_pulse; o_pready |=> !o_pready; endproperty
   a_pulse: assert property (p_pulse) else $error("pready too long");
   property p_err; o_pslverr |-> o_pready; endproperty
   a_err: assert property (p_err) else $error("pslverr without pready");
   property p_unmap; acs && i_paddr > 12'h024 |=> o_pslverr && o_prdata == 32'h0; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped access not refused");
   property p_start;
      $rose(o_busy) |-> $past(acs && i_pwrite && i_paddr == 12'h000 && i_pwdata[0]);
   endproperty
   a_start: assert property (p_start) else $error("busy without go");
   // One decode cycle plus twelve clocks per machine cycle
   property p_len;
      $fell(o_busy) && op_r[7:4] == 4'h6 |-> cnt_r == (op_r == 8'h63 ? 5'h19 : 5'h0d);
   endproperty
   a_len: assert property (p_len) else $error("wrong execute length");
   // Latch moves only on its own write or at the end of an instruction
   property p_latch;
      $changed(o_port_latch) |-> $fell(o_busy) || $past(acs && i_pwrite && i_paddr == 12'h014);
   endproperty
   a_latch: assert property (p_latch) else $error("port latch moved");
   property p_rst; $rose(i_rst_n) |-> o_port_latch == 8'hff && !o_busy && !o_pready; endproperty
   a_rst: assert property (p_rst) else $error("bad reset state");
   c_three: cover property ($fell(o_busy) && op_r == 8'h63);
   c_dst: cover property ($fell(o_busy) && op_r == 8'h62);
   c_err: cover property (o_pslverr);
endmodule
bind xsp_core xsp_core_checker u_chk (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
   .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
   .i_pwdata(i_pwdata), .i_port_pins(i_port_pins), .o_prdata(o_prdata),
   .o_pready(o_pready), .o_pslverr(o_pslverr), .o_port_latch(o_port_latch), .o_busy(o_busy));
